// >>> ccpw_regs.svh
// register offsets, field positions, reset values and timing counts of the pwm channel
`ifndef CCPW_REGS_SVH
`define CCPW_REGS_SVH

// byte offsets on the register bus
`define CCPW_OFS_PERIOD_COUNTER      8'h00
`define CCPW_OFS_PERIOD_VALUE        8'h04
`define CCPW_OFS_PERIOD_TIMER_CTRL   8'h08
`define CCPW_OFS_UNIT_CONTROL        8'h0C
`define CCPW_OFS_DUTY_LOW_BYTE       8'h10
`define CCPW_OFS_ACTIVE_DUTY_LATCH   8'h14
`define CCPW_OFS_STATUS              8'h18

// period timer control fields
`define CCPW_TCON_PRESCALE_LSB       0
`define CCPW_TCON_RUN_BIT            2
`define CCPW_TCON_POSTSCALE_LSB      3

// unit control fields
`define CCPW_CCON_MODE_LSB           0
`define CCPW_CCON_DUTY_FRAC_LSB      4
`define CCPW_CCON_PWM_MODE           2'h3

// status fields
`define CCPW_STAT_PIN_BIT            0
`define CCPW_STAT_POST_FLAG_BIT      1

// reset values
`define CCPW_RST_PERIOD_VALUE        8'hFF
`define CCPW_RST_ZERO                8'h00

// timing: oscillator periods per instruction cycle, clock period in ns
`define CCPW_OSC_PER_INSN            4
`define CCPW_CLK_PERIOD_NS           100

`endif

// >>> ccpw_pkg.sv
// types of the pwm channel: bus states and the packed state record
package ccpw_pkg;

   // bus slave phases, one-hot
   typedef enum logic [2:0]
   {
      BUS_IDLE = 3'b001,
      BUS_WR   = 3'b010,
      BUS_RDW  = 3'b100
   } ccpw_bus_e;

   // whole state of the channel
   typedef struct packed
   {
      ccpw_bus_e   bus;
      logic [5:0]  addr;
      logic [31:0] hrdata;
      logic [7:0]  tmr;
      logic [7:0]  pr;
      logic [6:0]  tcon;
      logic [5:0]  ccon;
      logic [7:0]  dlow;
      logic [9:0]  act;
      logic [1:0]  qph;
      logic [3:0]  presc;
      logic [3:0]  post;
      logic        pin;
      logic        post_pulse;
      logic        post_flag;
   } ccpw_state_s;

endpackage : ccpw_pkg

// >>> ccpw_pwm.sv
// single-output pwm channel with period timer and ahb-lite register slave
//
// Contract
// RULE_01 - pwm mode drives a modulated waveform with up to ten bits of duty
// RULE_02 - writing zero to unit control forces the unit output latch low
// RULE_03 - software clears the pin direction bit so the waveform reaches the pin
// RULE_04 - the period register sets the waveform period
// RULE_05 - counter equal to period value resets to zero on next increment
// RULE_06 - that increment sets the pin, unless the duty value is zero
// RULE_07 - at rollover the duty byte is copied into the active duty latch
// RULE_08 - the postscaler divides timer events only, never the waveform
// RULE_09 - duty is duty low byte as msbs and control bits 5:4 as lsbs
// RULE_10 - high time equals duty times oscillator period times prescale
// RULE_11 - duty writes at any time take effect after the next period match
// RULE_12 - the active duty latch is read-only while in pwm mode
// RULE_13 - active latch plus hidden two-bit latch double-buffer the duty
// RULE_14 - pin clears when active duty equals counter extended by two bits
// RULE_15 - duty beyond the period never clears the pin that period
// RULE_16 - prescaler divides by 1, 4 or 16
// RULE_17 - setup order: period, duty, pin output, timer on, then pwm mode
// RULE_18 - unscaled counter steps per four-clock cycle; phase gives low bits
`timescale 1ns/100ps
`include "ccpw_regs.svh"

module ccpw_pwm
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output wire logic        hreadyout,
   output wire logic        hresp,
   output wire logic [31:0] hrdata,
   output wire logic        pwm_unit_output,
   output wire logic        timer_post_event
);

   ccpw_pkg::ccpw_state_s st_q;
   ccpw_pkg::ccpw_state_s st_d;

   // time base and waveform decode
   logic        pwm_mode;
   logic        run;
   logic [1:0]  ps_sel;
   logic        insn_end;
   logic        inc;
   logic [1:0]  nxt_low;
   logic [9:0]  nxt_ext;
   logic [9:0]  new_duty;

   // bus side helpers
   logic        accept;
   logic [7:0]  wofs;
   logic [7:0]  rofs;
   logic        post_set;
   logic [31:0] rd_val;

   // decoded controls
   // only mode 11 in bits 3:2 lets the waveform out
   assign pwm_mode = st_q.ccon[`CCPW_CCON_MODE_LSB + 3 -: 2] == `CCPW_CCON_PWM_MODE;
   assign run      = st_q.tcon[`CCPW_TCON_RUN_BIT];
   assign ps_sel   = st_q.tcon[`CCPW_TCON_PRESCALE_LSB +: 2];
   assign insn_end = st_q.qph == 2'(`CCPW_OSC_PER_INSN - 1); // RULE_18

   // address phase qualifier and word offsets
   assign accept   = hsel && htrans[1] && hready;
   assign wofs     = {st_q.addr, 2'b00};
   assign rofs     = {st_q.addr, 2'b00};

   // duty assembled from low byte and fraction bits
   // only read at rollover, so software may write either part at any time
   assign new_duty = {st_q.dlow, st_q.ccon[`CCPW_CCON_DUTY_FRAC_LSB +: 2]}; // RULE_09

   // increment tick per prescale choice
   // the prescaler counts instruction cycles, so ratios 4 and 16 stay exact
   always_comb
   begin
      case (ps_sel)
         2'b00:
         begin
            inc = run && insn_end; // RULE_16 RULE_18
         end
         2'b01:
         begin
            inc = run && insn_end && (st_q.presc[1:0] == 2'b11); // RULE_16
         end
         default:
         begin
            inc = run && insn_end && (st_q.presc == 4'hF); // RULE_16
         end
      endcase
   end

   // read mux
   // upper bits always read zero, unmapped offsets read zero
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (rofs)
         `CCPW_OFS_PERIOD_COUNTER:
         begin
            rd_val[7:0] = st_q.tmr;
         end
         `CCPW_OFS_PERIOD_VALUE:
         begin
            rd_val[7:0] = st_q.pr;
         end
         `CCPW_OFS_PERIOD_TIMER_CTRL:
         begin
            rd_val[6:0] = st_q.tcon;
         end
         `CCPW_OFS_UNIT_CONTROL:
         begin
            rd_val[5:0] = st_q.ccon;
         end
         `CCPW_OFS_DUTY_LOW_BYTE:
         begin
            rd_val[7:0] = st_q.dlow;
         end
         `CCPW_OFS_ACTIVE_DUTY_LATCH:
         begin
            rd_val[7:0] = st_q.act[9:2];
         end
         `CCPW_OFS_STATUS:
         begin
            rd_val[`CCPW_STAT_PIN_BIT]       = st_q.pin;
            rd_val[`CCPW_STAT_POST_FLAG_BIT] = st_q.post_flag;
         end
         default:
         begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // next state: time base, waveform, then bus
   // quarter phase wraps every four clocks, one instruction cycle
   // prescale 1 steps the counter every instruction cycle
   // prescale 4 steps it every fourth instruction cycle
   // prescale 16 steps it every sixteenth instruction cycle
   // a step at the period value wraps the counter to zero
   // the same step latches the new duty and sets the pin
   // a zero duty leaves the pin low for the whole period
   // the pin drops when the next extended count meets the duty
   // a duty beyond the period never meets it, the pin stays high
   // the postscaler only counts matches for the event output
   // bus writes are applied last and override the time base, except a flag clear
   // a zero unit control write drops the pin the same edge
   always_comb
   begin
      st_d            = st_q;
      st_d.post_pulse = 1'b0;
      post_set        = 1'b0;

      // quarter-cycle phase runs from the oscillator
      // free running, so a new prescale choice keeps its phase
      st_d.qph = 2'(st_q.qph + 2'b01); // RULE_18

      // prescaler counts instruction cycles while running
      // writing the counter clears it, giving a whole first tick
      if (run && insn_end)
      begin
         st_d.presc = 4'(st_q.presc + 4'h1);
      end

      // period match and rollover
      // in pwm mode duty and pin set change only here, keeping the waveform glitch free
      if (inc)
      begin
         if (st_q.tmr == st_q.pr) // RULE_04
         begin
            st_d.tmr = 8'h00;    // RULE_05
            st_d.act = new_duty; // RULE_07 RULE_11 RULE_13
            st_d.pin = pwm_mode && (new_duty != 10'h000); // RULE_06 RULE_01
            // postscaler only divides events, waveform untouched
            if (st_q.post == st_q.tcon[`CCPW_TCON_POSTSCALE_LSB +: 4]) // RULE_08
            begin
               st_d.post       = 4'h0;
               st_d.post_pulse = 1'b1;
               post_set        = 1'b1;
            end
            else
            begin
               st_d.post = 4'(st_q.post + 4'h1);
            end
         end
         else
         begin
            // plain step between matches
            st_d.tmr = 8'(st_q.tmr + 8'h01);
         end
      end

      // extended count that stands after this edge
      case (ps_sel)
         2'b00:
         begin
            nxt_low = st_d.qph; // RULE_18
         end
         2'b01:
         begin
            nxt_low = st_d.presc[1:0];
         end
         default:
         begin
            nxt_low = st_d.presc[3:2];
         end
      endcase
      nxt_ext = {st_d.tmr, nxt_low}; // RULE_14 RULE_10

      // duty compare clears the pin; never matches if duty exceeds period
      // comparing the next count keeps the high time at exactly duty times prescale clocks
      if (st_d.pin && (nxt_ext == st_d.act)) // RULE_14 RULE_15 RULE_10
      begin
         st_d.pin = 1'b0;
      end

      // output latch held low outside pwm mode
      if (!pwm_mode)
      begin
         st_d.pin = 1'b0; // RULE_02
      end

      // sticky postscaled event flag
      // a clear written in the same cycle loses to the set
      if (post_set)
      begin
         st_d.post_flag = 1'b1;
      end

      // bus data phase
      // hwdata stands in this cycle; the write lands at its end
      case (st_q.bus)
         ccpw_pkg::BUS_WR:
         begin
            case (wofs)
               `CCPW_OFS_PERIOD_COUNTER:
               begin
                  // restart the prescaler so the next tick is whole
                  st_d.tmr   = hwdata[7:0];
                  st_d.presc = 4'h0;
               end
               `CCPW_OFS_PERIOD_VALUE:
               begin
                  st_d.pr = hwdata[7:0]; // RULE_04
               end
               `CCPW_OFS_PERIOD_TIMER_CTRL:
               begin
                  st_d.tcon = hwdata[6:0];
               end
               `CCPW_OFS_UNIT_CONTROL:
               begin
                  st_d.ccon = hwdata[5:0]; // RULE_11
                  if (hwdata[5:0] == 6'h00)
                  begin
                     st_d.pin = 1'b0; // RULE_02
                  end
               end
               `CCPW_OFS_DUTY_LOW_BYTE:
               begin
                  st_d.dlow = hwdata[7:0]; // RULE_11
               end
               `CCPW_OFS_ACTIVE_DUTY_LATCH:
               begin
                  // software may preload the latch only outside pwm mode
                  if (!pwm_mode) // RULE_12
                  begin
                     st_d.act[9:2] = hwdata[7:0];
                  end
               end
               `CCPW_OFS_STATUS:
               begin
                  // set wins over a write-one clear
                  if (hwdata[`CCPW_STAT_POST_FLAG_BIT] && !post_set)
                  begin
                     st_d.post_flag = 1'b0;
                  end
               end
               default:
               begin
                  // unmapped offsets take no write
                  st_d.post_flag = st_d.post_flag;
               end
            endcase
         end
         ccpw_pkg::BUS_RDW:
         begin
            // captured once, stands until the next read
            st_d.hrdata = rd_val;
         end
         default:
         begin
            // idle keeps the last read data
            st_d.hrdata = st_q.hrdata;
         end
      endcase

      // address phase
      // the read wait cycle takes no new address
      if (st_q.bus == ccpw_pkg::BUS_RDW)
      begin
         st_d.bus = ccpw_pkg::BUS_IDLE;
      end
      else if (accept)
      begin
         st_d.addr = haddr[7:2];
         st_d.bus  = hwrite ? ccpw_pkg::BUS_WR : ccpw_pkg::BUS_RDW;
      end
      else
      begin
         st_d.bus = ccpw_pkg::BUS_IDLE;
      end
   end

   // state register
   // period value resets to all ones, the bus phase to idle, everything else to zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q            <= '0;
         st_q.bus        <= ccpw_pkg::BUS_IDLE;
         st_q.pr         <= `CCPW_RST_PERIOD_VALUE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // bus answer
   assign hreadyout        = st_q.bus != ccpw_pkg::BUS_RDW; // one wait state on reads
   assign hresp            = 1'b0;
   assign hrdata           = st_q.hrdata;

   // pin level and postscaled event
   assign pwm_unit_output  = st_q.pin; // RULE_01 RULE_03
   assign timer_post_event = st_q.post_pulse;

endmodule : ccpw_pwm

// >>> ccpw_pwm_checker.sv
// assertions on the ports of the pwm channel
`timescale 1ns/100ps
module ccpw_pwm_checker
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        pwm_unit_output,
   input wire logic        timer_post_event
);
   wire logic acc = hsel && htrans[1] && hready;
   logic      zc_q;
   // write address phase to unit control
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         zc_q <= 1'b0;
      else if (hready)
         zc_q <= acc && hwrite && haddr[7:2] == 6'h03;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   chk_read_wait: assert property (acc && !hwrite |=> s_wait)
      else $error("read wait wrong");
   chk_write_nowait: assert property (acc && hwrite |=> hreadyout)
      else $error("write waited");
   chk_wait_one: assert property (!hreadyout |=> hreadyout)
      else $error("wait too long");
   chk_wait_cause: assert property (!hreadyout |-> $past(acc && !hwrite))
      else $error("wait without read");
   chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("hrdata moved");
   chk_post_gap: assert property (timer_post_event |=> !timer_post_event [*3])
      else $error("post pulses too close");
   chk_zero_ctrl: assert property (zc_q && hwdata == 32'h0 |=> ##1 !pwm_unit_output)
      else $error("pin high after zero control");
endmodule : ccpw_pwm_checker

bind ccpw_pwm ccpw_pwm_checker ccpw_pwm_checker_inst (.*);

// >>> ccpw_load.sv
// external load: measures high time and period of the pin
`timescale 1ns/100ps
module ccpw_load
(
   input wire logic         hclk,
   input wire logic         pin_dir_out,
   input wire logic         pwm_unit_output,
   output logic      [15:0] hi_len,
   output logic      [15:0] per_len
);
   logic        pad_q;
   logic [15:0] cnt_q;
   wire logic   pad = pin_dir_out & pwm_unit_output;
   // run length since last rise, latched on each edge of the pad
   always_ff @(posedge hclk)
   begin
      pad_q <= pad;
      cnt_q <= (pad && !pad_q) ? 16'h1 : cnt_q + 16'h1;
      if (pad && !pad_q)
         per_len <= cnt_q;
      if (!pad && pad_q)
         hi_len <= cnt_q;
   end
endmodule : ccpw_load

// >>> testbench.sv
// self-checking bench of the pwm channel
`timescale 1ns/100ps
`include "ccpw_regs.svh"
`define CHK(nm, e, s) n_tests++; if ((s) !== (e)) begin \
   $display("FAIL %s exp %h got %h", nm, e, s); err_total++; end
module testbench;
   logic             hclk;
   logic             hresetn;
   logic             hsel;
   logic [7:0]       haddr;
   logic [1:0]       htrans;
   logic             hwrite;
   logic [2:0]       hsize;
   logic [31:0]      hwdata;
   logic             pin_dir_out;
   wire logic        hready;
   wire logic        hreadyout;
   wire logic        hresp;
   wire logic [31:0] hrdata;
   wire logic        pwm_unit_output;
   wire logic        timer_post_event;
   wire logic [15:0] hi_len;
   wire logic [15:0] per_len;
   int               err_total;
   int               n_tests;
   logic [15:0]      c;
   assign hready = hreadyout;
   ccpw_pwm ccpw_pwm_inst (.*);
   ccpw_load ccpw_load_inst (.*);
   // clock and watchdog
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   initial
   begin
      #2000000;
      err_total++;
      end_of_test();
   end
   task automatic end_of_test;
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // one single ahb-lite transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      `CHK("reg", e, r)
   endtask : rdc
   // count high cycles at the load, or post pulses
   task automatic cnt(input int n, input logic post);
      c = 16'h0;
      repeat (n)
      begin
         @(posedge hclk);
         c = c + 16'(post ? timer_post_event : pin_dir_out & pwm_unit_output);
      end
   endtask : cnt
   task automatic t_setup;
      rdc(8'h04, 32'hFF);
      rdc(8'h1C, 32'h0);
      wr(8'h04, 32'h3);
      wr(8'h10, 32'h2);
      wr(8'h0C, 32'h20);
      pin_dir_out <= 1'b1;
      wr(8'h08, 32'h4);
      wr(8'h0C, 32'h2C);
      repeat (40) @(posedge hclk);
      `CHK("high", 16'(2 * 4 + 2), hi_len)
      `CHK("period", 16'((3 + 1) * `CCPW_OSC_PER_INSN), per_len)
   endtask : t_setup
   task automatic t_update;
      @(posedge pwm_unit_output);
      wr(8'h10, 32'h1);
      rdc(8'h14, 32'h2);
      wr(8'h14, 32'hFF);
      repeat (40) @(posedge hclk);
      rdc(8'h14, 32'h1);
      `CHK("high", 16'(1 * 4 + 2), hi_len)
   endtask : t_update
   task automatic t_presc;
      wr(8'h10, 32'h2);
      for (int i = 1; i < 3; i++)
      begin
         wr(8'h08, 32'(4 + i));
         repeat (48 * 4 ** i) @(posedge hclk);
         `CHK("high ps", 16'(10 * 4 ** i), hi_len)
         `CHK("period ps", 16'(16 * 4 ** i), per_len)
      end
      wr(8'h08, 32'h0C);
      repeat (20) @(posedge hclk);
      cnt(64, 1'b1);
      `CHK("post", 16'h2, c)
      `CHK("period post", 16'h10, per_len)
   endtask : t_presc
   task automatic t_edges;
      wr(8'h10, 32'h7);
      repeat (40) @(posedge hclk);
      cnt(32, 1'b0);
      `CHK("long duty", 16'h20, c)
      wr(8'h10, 32'h0);
      wr(8'h0C, 32'h0C);
      repeat (40) @(posedge hclk);
      cnt(32, 1'b0);
      `CHK("zero duty", 16'h0, c)
      wr(8'h10, 32'h2);
      repeat (40) @(posedge hclk);
      wr(8'h0C, 32'h0);
      repeat (2) @(posedge hclk);
      cnt(32, 1'b0);
      `CHK("ctrl zero", 16'h0, c)
   endtask : t_edges
   // reset, then the scenarios
   initial
   begin
      err_total = 0;
      n_tests = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pin_dir_out = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_setup();
      t_update();
      t_presc();
      t_edges();
      end_of_test();
   end
endmodule : testbench
